// ==== sim/mmt16_pin_model.sv ====
// outside pulse source on the timer pad
// assumes the bench calls pulse from a process timed on clk_sys
`timescale 1ns/100ps
module mmt16_pin_model (
    input wire logic clk_sys,
    output logic pin
);
    int cyc = 0;
    int t_rise = 0;
    int t_fall = 0;
    initial pin = 1'b0;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
    end
    // levels last whole clock cycles, so no pulse is under one cycle
    task automatic pulse(input int h, input int l);
        @(posedge clk_sys);
        pin <= 1'b1;
        t_rise = cyc;
        repeat (h) @(posedge clk_sys);
        pin <= 1'b0;
        t_fall = cyc;
        repeat (l) @(posedge clk_sys);
    endtask
endmodule // mmt16_pin_model

// ==== sim/mmt16_timer_props.sv ====
// checker of the timer's byte port, interrupt gating and pin sharing
// sees only the ports of mmt16_timer, attached by the bind below
`timescale 1ns/100ps
`include "mmt16_defines.svh"
module mmt16_timer_props (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [2:0] reg_sel,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic global_irq_enable,
    input wire logic timer_interrupt,
    input wire logic port_oe_n,
    input wire logic timer_pin_in,
    input wire logic timer_pin_oe_n,
    input wire logic shared_port_bit_in
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence s_ctrl_wr;
        reg_wr && reg_sel == `MMT16_SEL_CTRL;
    endsequence
    // one idle cycle, then a read of the control byte
    sequence s_ctrl_rd;
        !reg_wr ##1 (reg_rd && !reg_wr && reg_sel == `MMT16_SEL_CTRL);
    endsequence
    a_pin_dir_pass: assert property (timer_pin_oe_n == port_oe_n)
        else $error("pin direction differs from port");
    a_pad_to_port: assert property (shared_port_bit_in == timer_pin_in)
        else $error("port bit differs from pad");
    a_irq_needs_global: assert property (!global_irq_enable |-> !timer_interrupt)
        else $error("interrupt without global enable");
    a_irq_enable_off: assert property (s_ctrl_wr ##0 !reg_wdata[`MMT16_BIT_IRQEN] |=> !timer_interrupt)
        else $error("interrupt after enable cleared");
    a_unmapped_zero: assert property (reg_rd && reg_sel > `MMT16_SEL_CTRL |=> reg_rdata == 8'h00)
        else $error("unmapped select read not zero");
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without read");
    a_rsvd_bit_zero: assert property (reg_rd && reg_sel == `MMT16_SEL_CTRL |=> !reg_rdata[0])
        else $error("reserved control bit read as one");
    a_ctrl_readback: assert property (s_ctrl_wr ##1 s_ctrl_rd |=>
        (reg_rdata & 8'hE6) == ($past(reg_wdata, 3) & 8'hE6))
        else $error("control byte readback differs");
endmodule // mmt16_timer_props
bind mmt16_timer mmt16_timer_props i_mmt16_timer_props (.clk_sys(clk_sys), .srst(srst), .reg_sel(reg_sel),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .global_irq_enable(global_irq_enable), .timer_interrupt(timer_interrupt), .port_oe_n(port_oe_n),
    .timer_pin_in(timer_pin_in), .timer_pin_oe_n(timer_pin_oe_n), .shared_port_bit_in(shared_port_bit_in));

// ==== sim/mmt16_timer_tb.sv ====
// self-checking bench of the multimode timer
// assumes the pad model is the only driver of the timer pin
`timescale 1ns/100ps
`include "mmt16_defines.svh"
module mmt16_timer_tb;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [2:0] reg_sel = 3'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic global_irq_enable = 1'b1;
    logic timer_interrupt;
    logic port_out = 1'b0;
    logic port_oe_n = 1'b1;
    logic pin;
    logic timer_pin_out;
    logic timer_pin_oe_n;
    logic shared_port_bit_in;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    mmt16_timer i_mmt16_timer (.clk_sys(clk_sys), .srst(srst), .reg_sel(reg_sel), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .global_irq_enable(global_irq_enable),
        .timer_interrupt(timer_interrupt), .port_out(port_out), .port_oe_n(port_oe_n), .timer_pin_in(pin),
        .timer_pin_out(timer_pin_out), .timer_pin_oe_n(timer_pin_oe_n), .shared_port_bit_in(shared_port_bit_in));
    mmt16_pin_model i_mmt16_pin_model (.clk_sys(clk_sys), .pin(pin));
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        @(posedge clk_sys);
        reg_sel <= s;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] s, output logic [7:0] v);
        @(posedge clk_sys);
        reg_sel <= s;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic wr16(input logic [2:0] s, input logic [15:0] d);
        wr(s, d[7:0]);
        wr(s + 3'h1, d[15:8]);
    endtask
    task automatic rd16(input logic [2:0] s, output logic [15:0] v);
        rd(s, v[7:0]);
        rd(s + 3'h1, v[15:8]);
    endtask
    // waits to the first cycle with the interrupt seen high
    task automatic wait_irq(output int n);
        n = 0;
        do begin
            @(posedge clk_sys);
            #1 n++;
        end while (timer_interrupt !== 1'b1 && n < 200);
    endtask
    task automatic t_reset;
        logic [15:0] v;
        rd16(`MMT16_SEL_CNT_LO, v);
        chk("count", 16'hFFFF, v);
        rd16(`MMT16_SEL_RLD_LO, v);
        chk("reload", 16'h0000, v);
        rd16(`MMT16_SEL_CTRL, v);
        chk("ctrl and unmapped", 16'h0000, v);
        $display("test reset done");
    endtask
    task automatic t_pwm;
        int n;
        logic [7:0] b;
        logic held;
        logic changed;
        @(posedge clk_sys);
        port_oe_n <= 1'b0;
        wr16(`MMT16_SEL_CNT_LO, 16'h0003);
        wr16(`MMT16_SEL_RLD_LO, 16'h0006);
        wr(`MMT16_SEL_CTRL, 8'hB4);
        wait_irq(n);
        chk("cycles to underflow", 16'h0004, n[15:0]);
        @(posedge clk_sys);
        #1 chk("pin toggled", 16'h0001, {15'h0000, timer_pin_out});
        repeat (7) @(posedge clk_sys);
        #1 chk("pin after reload period", 16'h0000, {15'h0000, timer_pin_out});
        rd(`MMT16_SEL_CTRL, b);
        chk("pending", 16'h0008, {8'h00, b & 8'h08});
        @(posedge clk_sys);
        global_irq_enable <= 1'b0;
        @(posedge clk_sys);
        #1 chk("irq masked", 16'h0000, {15'h0000, timer_interrupt});
        @(posedge clk_sys);
        global_irq_enable <= 1'b1;
        wr(`MMT16_SEL_CTRL, 8'h90);
        #1 held = timer_pin_out;
        changed = 1'b0;
        // two reload periods: any toggle shows as a change of level
        repeat (16) begin
            @(posedge clk_sys);
            #1 changed = changed | (timer_pin_out !== held);
        end
        chk("no toggle mode", 16'h0000, {15'h0000, changed});
        wr(`MMT16_SEL_CTRL, 8'h00);
        port_oe_n <= 1'b1;
        port_out <= 1'b1;
        @(posedge clk_sys);
        #1 chk("pin follows port", 16'h0001, {15'h0000, timer_pin_out});
        @(posedge clk_sys);
        port_out <= 1'b0;
        $display("test pwm done");
    endtask
    task automatic t_event;
        logic [15:0] v;
        for (int m = 0; m < 2; m++) begin
            wr(`MMT16_SEL_CTRL, 8'h00);
            wr16(`MMT16_SEL_CNT_LO, 16'h0001);
            wr16(`MMT16_SEL_RLD_LO, 16'h0002);
            wr(`MMT16_SEL_CTRL, m ? 8'h34 : 8'h14);
            i_mmt16_pin_model.pulse(3, 3);
            repeat (4) @(posedge clk_sys);
            #1 chk("irq after one edge", 16'h0000, {15'h0000, timer_interrupt});
            i_mmt16_pin_model.pulse(3, 3);
            repeat (4) @(posedge clk_sys);
            #1 chk("irq after two edges", 16'h0001, {15'h0000, timer_interrupt});
            rd16(`MMT16_SEL_CNT_LO, v);
            chk("count after underflow", 16'h0002, v);
        end
        $display("test event done");
    endtask
    task automatic t_capture;
        logic [15:0] c1;
        logic [15:0] c2;
        int t1;
        for (int m = 0; m < 2; m++) begin
            wr(`MMT16_SEL_CTRL, 8'h00);
            wr(`MMT16_SEL_CTRL, m ? 8'h64 : 8'h44);
            i_mmt16_pin_model.pulse(4, 4);
            t1 = m ? i_mmt16_pin_model.t_fall : i_mmt16_pin_model.t_rise;
            rd16(`MMT16_SEL_RLD_LO, c1);
            chk("capture irq", 16'h0001, {15'h0000, timer_interrupt});
            i_mmt16_pin_model.pulse(4, 4);
            t1 = (m ? i_mmt16_pin_model.t_fall : i_mmt16_pin_model.t_rise) - t1;
            rd16(`MMT16_SEL_RLD_LO, c2);
            chk("capture interval", t1[15:0], c1 - c2);
        end
        $display("test capture done");
    endtask
    task automatic t_diff;
        logic [15:0] exp [4] = '{16'h0005, 16'h000D, 16'h0008, 16'h000D};
        logic [15:0] v;
        logic [7:0] d;
        logic [7:0] b;
        for (int k = 0; k < 4; k++) begin
            wr(`MMT16_SEL_CTRL, 8'h00);
            d = 8'hC5 | {2'h0, k[1], 3'h0, k[0], 1'b0};
            wr(`MMT16_SEL_CTRL, d);
            rd(`MMT16_SEL_CTRL, b);
            chk("ctrl readback", {8'h00, d & 8'hE6}, {8'h00, b & 8'hE7});
            i_mmt16_pin_model.pulse(5, 7);
            i_mmt16_pin_model.pulse(5, 7);
            repeat (4) @(posedge clk_sys);
            rd16(`MMT16_SEL_RLD_LO, v);
            chk("difference", exp[k], v);
        end
        $display("test difference done");
    endtask
    // the whole sequence needs under four hundred cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            give_verdict;
        end
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        t_reset;
        t_pwm;
        t_event;
        t_capture;
        t_diff;
        give_verdict;
    end
endmodule // mmt16_timer_tb

// ==== src/mmt16_defines.svh ====
// constants of the 16-bit multimode timer: register selects, field positions, reset values
// included by the package, the timer and the down counter
`ifndef MMT16_DEFINES_SVH
`define MMT16_DEFINES_SVH
`define MMT16_SEL_CNT_LO 3'h0
`define MMT16_SEL_CNT_HI 3'h1
`define MMT16_SEL_RLD_LO 3'h2
`define MMT16_SEL_RLD_HI 3'h3
`define MMT16_SEL_CTRL 3'h4
`define MMT16_CNT_RESET 16'hFFFF
`define MMT16_RLD_RESET 16'h0000
`define MMT16_CTRL_RESET 8'h00
`define MMT16_CNT_MAX 16'hFFFF
`define MMT16_CNT_ZERO 16'h0000
`define MMT16_CNT_ONE 16'h0001
`define MMT16_BIT_MODE_C 7
`define MMT16_BIT_MODE_B 6
`define MMT16_BIT_MODE_A 5
`define MMT16_BIT_RUN 4
`define MMT16_BIT_PEND 3
`define MMT16_BIT_IRQEN 2
`define MMT16_BIT_CAPTYPE 1
`define MMT16_CTRL_RSVD_MASK 8'hFE
`endif

// ==== src/mmt16_down_counter.sv ====
// 16-bit down counter with load, decrement and underflow reload
// assumes load and dec come from logic on clk_sys; load wins over dec
`timescale 1ns/100ps
`include "mmt16_defines.svh"
module mmt16_down_counter
    import mmt16_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic load,
    input wire logic [15:0] load_value,
    input wire logic dec,
    input wire logic [15:0] reload_value,
    output logic [15:0] count,
    output logic underflow
);
    typedef struct packed {
        logic [15:0] count;
    } mmt16_cnt_state_t;
    mmt16_cnt_state_t state;
    mmt16_cnt_state_t next_state;

    always_comb begin
        next_state = state;
        if (load) begin
            next_state.count = load_value;
        end else if (dec) begin
            if (state.count == `MMT16_CNT_ZERO) begin
                next_state.count = reload_value;
            end else begin
                next_state.count = state.count - `MMT16_CNT_ONE;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state.count <= `MMT16_CNT_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign count = state.count;
    assign underflow = dec & ~load & (state.count == `MMT16_CNT_ZERO);
endmodule // mmt16_down_counter

// ==== src/mmt16_edge_detect.sv ====
// two-flop synchroniser of the timer pin with rising and falling edge pulses
// assumes pin_in is asynchronous to clk_sys
`timescale 1ns/100ps
module mmt16_edge_detect
    import mmt16_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic pin_in,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } mmt16_edge_state_t;
    mmt16_edge_state_t state;
    mmt16_edge_state_t next_state;

    always_comb begin
        next_state = state;
        next_state.meta = pin_in;
        next_state.sync = state.meta;
        next_state.last = state.sync;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // edges look only at sync and last, never at the first flop
    assign rise = state.sync & ~state.last;
    assign fall = ~state.sync & state.last;
endmodule // mmt16_edge_detect

// ==== src/mmt16_pkg.sv ====
// types of the 16-bit multimode timer
// used by every design module of the timer
`include "mmt16_defines.svh"
package mmt16_pkg;
    typedef enum logic [1:0] {
        mmt16_mode_event,
        mmt16_mode_pwm,
        mmt16_mode_capture,
        mmt16_mode_diff
    } mmt16_mode_t;
    typedef enum logic [1:0] {
        mmt16_diff_idle,
        mmt16_diff_wait_start,
        mmt16_diff_wait_end
    } mmt16_diff_t;
endpackage

// ==== src/mmt16_timer.sv ====
// 16-bit multimode timer: pwm, event counter, input capture, difference capture
// assumes a byte-wide core port on clk_sys (the instruction clock) and an external port pad
// Functional notes
// - 16-bit timer with four operating modes
// - count, reload/capture and control registers held
// - sixteen-bit registers accessed as byte pairs
// - reset values FFFF, 0000 and 00
// - timer pin shared with port bit
// - bit 4 runs timer or flags underflow
// - decrement count once per clock event
// - count clock is instruction clock or pin
// - underflow reloads, may interrupt or toggle pin
// - bit 2 enables interrupt; source mode dependent
// - bit 3 reads interrupt pending state
// - bit 1 picks capture type; bit 0 reserved
// - modes 000/001 count pin edges, underflow interrupt
// - modes 101/100 pwm reload, toggle on 101
// - mode 010 captures on rising pin edge
// - mode 011 captures on falling pin edge
// - mode 11x difference capture, edge pair select
// - input capture measures time between events
// - reload-mode underflow sets pending; irq needs both enables
// - pin edges sensed at half clock rate; ev_gap limits event mode only, capture modes sense edges every clock
// - capture copies count on selected edge
// - control register is readable and writable
`timescale 1ns/100ps
`include "mmt16_defines.svh"
module mmt16_timer
    import mmt16_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [2:0] reg_sel,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic global_irq_enable,
    output logic timer_interrupt,
    input wire logic port_out,
    input wire logic port_oe_n,
    input wire logic timer_pin_in,
    output logic timer_pin_out,
    output logic timer_pin_oe_n,
    output logic shared_port_bit_in
);
    typedef struct packed {
        logic [15:0] reload;
        logic [7:0] ctrl;
        logic toggle_out;
        logic [15:0] diff_start;
        mmt16_diff_t diff;
        logic ev_gap;
        logic [7:0] rdata;
    } mmt16_state_t;
    mmt16_state_t state;
    mmt16_state_t next_state;

    logic pin_rise;
    logic pin_fall;
    logic [15:0] count;
    logic underflow;
    logic cnt_load;
    logic [15:0] cnt_load_value;
    logic cnt_dec;
    logic [15:0] cnt_reload;
    mmt16_mode_t mode;
    logic mode_c;
    logic mode_b;
    logic mode_a;
    logic cap_type;
    logic run;
    logic event_edge;
    logic cap_edge;
    logic start_edge;
    logic end_edge;
    logic irq_source;
    logic [7:0] rd_byte;

    mmt16_edge_detect i_mmt16_edge_detect (
        .clk_sys(clk_sys),
        .srst(srst),
        .pin_in(timer_pin_in),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    // the count lives in its own module so a byte write and a decrement meet in one place
    mmt16_down_counter i_mmt16_down_counter (
        .clk_sys(clk_sys),
        .srst(srst),
        .load(cnt_load),
        .load_value(cnt_load_value),
        .dec(cnt_dec),
        .reload_value(cnt_reload),
        .count(count),
        .underflow(underflow)
    );

    assign mode_c = state.ctrl[`MMT16_BIT_MODE_C];
    assign mode_b = state.ctrl[`MMT16_BIT_MODE_B];
    assign mode_a = state.ctrl[`MMT16_BIT_MODE_A];
    assign cap_type = state.ctrl[`MMT16_BIT_CAPTYPE];
    assign run = state.ctrl[`MMT16_BIT_RUN];

    // mode decode from bits 7 and 6
    always_comb begin
        if (mode_b && mode_c) begin
            mode = mmt16_mode_diff;
        end else if (mode_b) begin
            mode = mmt16_mode_capture;
        end else if (mode_c) begin
            mode = mmt16_mode_pwm;
        end else begin
            mode = mmt16_mode_event;
        end
    end

    // event counter takes the chosen pin edge; ev_gap forbids two counts on
    // consecutive clocks so the sense rate stays at half the clock
    assign event_edge = (mode_a ? pin_fall : pin_rise) & ~state.ev_gap;
    assign cap_edge = mode_a ? pin_fall : pin_rise;

    // pair select: bit5/bit1 = 00 pos-neg, 01 pos-pos, 10 neg-pos, 11 neg-neg
    assign start_edge = mode_a ? pin_fall : pin_rise;
    assign end_edge = (mode_a ^ cap_type) ? pin_rise : pin_fall;

    // capture modes count from configuration on, not gated by the run bit
    always_comb begin
        cnt_dec = 1'b0;
        case (mode)
            mmt16_mode_event: begin
                cnt_dec = run & event_edge;
            end
            mmt16_mode_pwm: begin
                cnt_dec = run;
            end
            default: begin
                cnt_dec = 1'b1;
            end
        endcase
    end

    // capture modes wrap to all ones, reload modes use the reload register
    assign cnt_reload = (mode == mmt16_mode_event || mode == mmt16_mode_pwm)
        ? state.reload : `MMT16_CNT_MAX;

    // a count byte write overrides the decrement of that clock
    always_comb begin
        cnt_load = 1'b0;
        cnt_load_value = count;
        if (reg_wr && reg_sel == `MMT16_SEL_CNT_LO) begin
            cnt_load = 1'b1;
            cnt_load_value = {count[15:8], reg_wdata};
        end else if (reg_wr && reg_sel == `MMT16_SEL_CNT_HI) begin
            cnt_load = 1'b1;
            cnt_load_value = {reg_wdata, count[7:0]};
        end
    end

    // read mux; unmapped selects read as zero
    always_comb begin
        if (reg_sel == `MMT16_SEL_CNT_LO) begin
            rd_byte = count[7:0];
        end else if (reg_sel == `MMT16_SEL_CNT_HI) begin
            rd_byte = count[15:8];
        end else if (reg_sel == `MMT16_SEL_RLD_LO) begin
            rd_byte = state.reload[7:0];
        end else if (reg_sel == `MMT16_SEL_RLD_HI) begin
            rd_byte = state.reload[15:8];
        end else if (reg_sel == `MMT16_SEL_CTRL) begin
            rd_byte = state.ctrl & `MMT16_CTRL_RSVD_MASK;
        end else begin
            rd_byte = 8'h00;
        end
    end

    always_comb begin
        next_state = state;
        next_state.ev_gap = (mode == mmt16_mode_event) & run & event_edge;
        // byte reads come out of a register one clock after the strobe
        if (reg_rd) begin
            next_state.rdata = rd_byte;
        end

        // register writes; reserved bit 0 stays zero
        if (reg_wr) begin
            if (reg_sel == `MMT16_SEL_RLD_LO) begin
                next_state.reload[7:0] = reg_wdata;
            end else if (reg_sel == `MMT16_SEL_RLD_HI) begin
                next_state.reload[15:8] = reg_wdata;
            end else if (reg_sel == `MMT16_SEL_CTRL) begin
                next_state.ctrl = reg_wdata & `MMT16_CTRL_RSVD_MASK;
                if (reg_wdata[`MMT16_BIT_MODE_C:`MMT16_BIT_MODE_A] !=
                    state.ctrl[`MMT16_BIT_MODE_C:`MMT16_BIT_MODE_A]) begin
                    next_state.diff = mmt16_diff_idle;
                end
            end
        end

        // the pwm output level follows the port latch when the timer is idle
        if (!run || mode != mmt16_mode_pwm) begin
            next_state.toggle_out = port_out;
        end

        // hardware sets win over a clearing write in the same clock
        case (mode)
            mmt16_mode_event: begin
                if (underflow) begin
                    next_state.ctrl[`MMT16_BIT_PEND] = 1'b1;
                end
            end
            mmt16_mode_pwm: begin
                if (underflow) begin
                    next_state.ctrl[`MMT16_BIT_PEND] = 1'b1;
                    if (mode_a) begin
                        next_state.toggle_out = ~state.toggle_out;
                    end
                end
            end
            mmt16_mode_capture: begin
                if (underflow) begin
                    next_state.ctrl[`MMT16_BIT_RUN] = 1'b1;
                end
                if (cap_edge) begin
                    next_state.reload = count;
                    next_state.ctrl[`MMT16_BIT_PEND] = 1'b1;
                end
            end
            default: begin
                if (underflow) begin
                    next_state.ctrl[`MMT16_BIT_RUN] = 1'b1;
                end
                case (state.diff)
                    mmt16_diff_idle: begin
                        next_state.diff = mmt16_diff_wait_start;
                    end
                    mmt16_diff_wait_start: begin
                        if (start_edge) begin
                            next_state.diff_start = count;
                            next_state.diff = mmt16_diff_wait_end;
                        end
                    end
                    default: begin
                        if (end_edge) begin
                            // down counter: elapsed = start - end
                            next_state.reload = state.diff_start - count;
                            next_state.ctrl[`MMT16_BIT_PEND] = 1'b1;
                            next_state.diff = mmt16_diff_wait_start;
                        end
                    end
                endcase
            end
        endcase
    end

    // reset puts every register in the state the core expects at start-up
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state.reload <= `MMT16_RLD_RESET;
            state.ctrl <= `MMT16_CTRL_RESET;
            state.toggle_out <= 1'b0;
            state.diff_start <= `MMT16_CNT_ZERO;
            state.diff <= mmt16_diff_idle;
            state.ev_gap <= 1'b0;
            state.rdata <= 8'h00;
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata = state.rdata;
    // in capture modes bit 4 is an underflow flag and also requests service
    always_comb begin
        irq_source = 1'b0;
        case (mode)
            mmt16_mode_capture: begin
                irq_source = state.ctrl[`MMT16_BIT_PEND] | state.ctrl[`MMT16_BIT_RUN];
            end
            mmt16_mode_diff: begin
                irq_source = state.ctrl[`MMT16_BIT_PEND] | state.ctrl[`MMT16_BIT_RUN];
            end
            default: begin
                // reload modes: the pending flag alone, set at every underflow
                irq_source = state.ctrl[`MMT16_BIT_PEND];
            end
        endcase
    end
    // the core sees the request only with both enables set
    assign timer_interrupt = global_irq_enable & state.ctrl[`MMT16_BIT_IRQEN] & irq_source;
    // only pwm mode takes the pin as an output; other modes leave it to the port
    always_comb begin
        if (mode == mmt16_mode_pwm) begin
            timer_pin_out = state.toggle_out;
        end else begin
            timer_pin_out = port_out;
        end
    end
    assign timer_pin_oe_n = port_oe_n;
    assign shared_port_bit_in = timer_pin_in;
endmodule // mmt16_timer
